/* File: design/codec_ctrl_pkg.sv */
// Package: register map, field positions, reset values and codes for the codec control bank.
// Assumes one core clock domain; the host writes whole 9-bit words by register address.
package codec_ctrl_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 9;
    localparam logic [6:0] ADDR_POWER = 7'h06;
    localparam logic [6:0] ADDR_FORMAT = 7'h07;
    localparam logic [6:0] ADDR_SAMPLING = 7'h08;
    localparam logic [6:0] ADDR_ACTIVATE = 7'h09;
    localparam logic [8:0] RST_POWER = 9'h09D;
    localparam logic [8:0] RST_FORMAT = 9'h00A;
    localparam logic [8:0] RST_SAMPLING = 9'h000;
    localparam logic [8:0] RST_ACTIVATE = 9'h000;
    localparam int PWR_LINEIN = 0;
    localparam int PWR_ADC = 2;
    localparam int PWR_DAC = 3;
    localparam int PWR_LINEOUT = 4;
    localparam int PWR_OFF = 7;
    localparam int FMT_LSB = 0;
    localparam int WL_LSB = 2;
    localparam int FMT_PHASE = 4;
    localparam int FMT_SWAP = 5;
    localparam int FMT_MASTER = 6;
    localparam int FMT_BIT_CLOCK_INVERT = 7;
    localparam int SMP_FIXED = 0;
    localparam int SMP_BASE_OVERSAMPLE_RATIO = 1;
    localparam int SR_LSB = 2;
    localparam int SMP_HALVE = 6;
    localparam int ACT_BIT = 0;
    localparam logic [1:0] FMT_DSP = 2'h3;
    localparam logic [1:0] FMT_I2S = 2'h2;
    localparam logic [1:0] FMT_LEFT = 2'h1;
    localparam logic [1:0] FMT_RIGHT = 2'h0;
    localparam logic [8:0] OSR_250 = 9'h0FA;
    localparam logic [8:0] OSR_272 = 9'h110;
    localparam logic [8:0] OSR_256 = 9'h100;
    localparam logic [8:0] OSR_384 = 9'h180;
    localparam int BCLK_HALF_TICKS = 2;
    localparam int SLOT_BITS = 32;
endpackage : codec_ctrl_pkg

/* File: design/fmt_if.sv */
// Interface: format and sampling fields into the decoder and its decoded answers.
// Assumes both ends sit on the core clock; carries levels only.
`timescale 1ns/100ps
interface fmt_if;
    logic [1:0] formatSel;
    logic [1:0] wordCode;
    logic phaseSel;
    logic fixedMode;
    logic base_oversample_ratio;
    logic [5:0] wordBits;
    logic [1:0] msbDelay;
    logic [8:0] oversampleRatio;
    modport regs (output formatSel, wordCode, phaseSel, fixedMode, base_oversample_ratio,
                  input wordBits, msbDelay, oversampleRatio);
    modport dec (input formatSel, wordCode, phaseSel, fixedMode, base_oversample_ratio,
                 output wordBits, msbDelay, oversampleRatio);
endinterface : fmt_if

/* File: design/fmt_decode.sv */
// Decoder: turns format and sampling codes into word length, MSB delay and clock ratio.
// Assumes stable register fields; purely combinational.
`timescale 1ns/100ps
module fmt_decode (
    fmt_if.dec f
);
    always_comb begin
        case (f.wordCode)
            2'h3: f.wordBits = 6'h20;
            2'h2: f.wordBits = 6'h18;
            2'h1: f.wordBits = 6'h14;
            default: f.wordBits = 6'h10;
        endcase
    end

    always_comb begin
        if (f.formatSel == codec_ctrl_pkg::FMT_DSP) begin
            f.msbDelay = f.phaseSel ? 2'h2 : 2'h1;
        end else if (f.formatSel == codec_ctrl_pkg::FMT_I2S) begin
            f.msbDelay = 2'h1;
        end else begin
            f.msbDelay = 2'h0;
        end
    end

    always_comb begin
        if (f.fixedMode) begin
            f.oversampleRatio = f.base_oversample_ratio ? codec_ctrl_pkg::OSR_272 : codec_ctrl_pkg::OSR_250;
        end else begin
            f.oversampleRatio = f.base_oversample_ratio ? codec_ctrl_pkg::OSR_384 : codec_ctrl_pkg::OSR_256;
        end
    end
endmodule : fmt_decode

/* File: design/codec_ctrl_regs.sv */
// Top: control register bank, power state, format decode and master audio clock generation.
// Assumes the host write port is on core_clk; pin inputs are asynchronous and synchronised here.
`timescale 1ns/100ps
module codec_ctrl_regs (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ctrlWrite,
    input wire logic [6:0] ctrlAddr,
    input wire logic [8:0] ctrlWdata,
    output logic [8:0] ctrlRdata,
    output logic lineInPowerDown,
    output logic adcPowerDown,
    output logic dacPowerDown,
    output logic lineOutPowerDown,
    output logic powerOff,
    output logic standby,
    output logic vmidEnable,
    output logic [1:0] formatSel,
    output logic [5:0] wordBits,
    output logic [1:0] msbDelay,
    output logic dacChannelSwap,
    output logic clockMaster,
    output logic bitClockInvert,
    output logic fixedClockMode,
    output logic [8:0] oversampleRatio,
    output logic [3:0] sampleRateCode,
    output logic coreClockHalve,
    output logic coreClkEnable,
    output logic interfaceActive,
    output logic rightChannelNow,
    input wire logic bitClkIn,
    output logic bitClkOut,
    output logic bitClkOe,
    input wire logic dacFrameIn,
    output logic dacFrameOut,
    output logic dacFrameOe,
    input wire logic adcFrameIn,
    output logic adcFrameOut,
    output logic adcFrameOe
);
    typedef enum logic [1:0] {GEN_IDLE, GEN_RUN} gen_e;

    logic [8:0] powerReg_ff;
    logic [8:0] formatReg_ff;
    logic [8:0] samplingReg_ff;
    logic [8:0] activateReg_ff;
    logic halvePhase_ff;
    gen_e genState_ff;
    gen_e nxt_genState;
    logic [3:0] tickCnt_ff;
    logic bclk_ff;
    logic [5:0] bitCnt_ff;
    logic frameRaw;
    logic bitClkOut_ff;
    logic dacFrameOut_ff;
    logic adcFrameOut_ff;
    logic [1:0] bclkSync_ff;
    logic [1:0] dacSync_ff;
    logic [1:0] adcSync_ff;
    logic rightNow_ff;
    logic genEnable;
    logic frameLevel;
    logic halfDone;

    fmt_if fbus ();

    fmt_decode u_dec (
        .f(fbus)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            powerReg_ff <= codec_ctrl_pkg::RST_POWER;
        end else if (ctrlWrite && ctrlAddr == codec_ctrl_pkg::ADDR_POWER) begin
            powerReg_ff <= ctrlWdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            formatReg_ff <= codec_ctrl_pkg::RST_FORMAT;
        end else if (ctrlWrite && ctrlAddr == codec_ctrl_pkg::ADDR_FORMAT) begin
            formatReg_ff <= ctrlWdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            samplingReg_ff <= codec_ctrl_pkg::RST_SAMPLING;
        end else if (ctrlWrite && ctrlAddr == codec_ctrl_pkg::ADDR_SAMPLING) begin
            samplingReg_ff <= ctrlWdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            activateReg_ff <= codec_ctrl_pkg::RST_ACTIVATE;
        end else if (ctrlWrite && ctrlAddr == codec_ctrl_pkg::ADDR_ACTIVATE) begin
            activateReg_ff <= ctrlWdata;
        end
    end

    // readback of the addressed word; other addresses of the 128 are not held here
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrlRdata <= 9'h000;
        end else if (ctrlAddr == codec_ctrl_pkg::ADDR_POWER) begin
            ctrlRdata <= powerReg_ff;
        end else if (ctrlAddr == codec_ctrl_pkg::ADDR_FORMAT) begin
            ctrlRdata <= formatReg_ff;
        end else if (ctrlAddr == codec_ctrl_pkg::ADDR_SAMPLING) begin
            ctrlRdata <= samplingReg_ff;
        end else if (ctrlAddr == codec_ctrl_pkg::ADDR_ACTIVATE) begin
            ctrlRdata <= activateReg_ff;
        end else begin
            ctrlRdata <= 9'h000;
        end
    end

    assign lineInPowerDown = powerReg_ff[codec_ctrl_pkg::PWR_LINEIN];
    assign adcPowerDown = powerReg_ff[codec_ctrl_pkg::PWR_ADC];
    assign dacPowerDown = powerReg_ff[codec_ctrl_pkg::PWR_DAC];
    assign lineOutPowerDown = powerReg_ff[codec_ctrl_pkg::PWR_LINEOUT];
    assign powerOff = powerReg_ff[codec_ctrl_pkg::PWR_OFF];
    assign standby = !powerOff && lineInPowerDown && adcPowerDown && dacPowerDown && lineOutPowerDown;
    assign vmidEnable = !powerOff;

    assign formatSel = formatReg_ff[codec_ctrl_pkg::FMT_LSB +: 2];
    assign dacChannelSwap = formatReg_ff[codec_ctrl_pkg::FMT_SWAP];
    assign clockMaster = formatReg_ff[codec_ctrl_pkg::FMT_MASTER];
    assign bitClockInvert = formatReg_ff[codec_ctrl_pkg::FMT_BIT_CLOCK_INVERT];
    assign fixedClockMode = samplingReg_ff[codec_ctrl_pkg::SMP_FIXED];
    assign sampleRateCode = samplingReg_ff[codec_ctrl_pkg::SR_LSB +: 4];
    assign coreClockHalve = samplingReg_ff[codec_ctrl_pkg::SMP_HALVE];
    assign interfaceActive = activateReg_ff[codec_ctrl_pkg::ACT_BIT];

    assign fbus.formatSel = formatSel;
    assign fbus.wordCode = formatReg_ff[codec_ctrl_pkg::WL_LSB +: 2];
    assign fbus.phaseSel = formatReg_ff[codec_ctrl_pkg::FMT_PHASE];
    assign fbus.fixedMode = fixedClockMode;
    assign fbus.base_oversample_ratio = samplingReg_ff[codec_ctrl_pkg::SMP_BASE_OVERSAMPLE_RATIO];
    assign wordBits = fbus.wordBits;
    assign msbDelay = fbus.msbDelay;
    assign oversampleRatio = fbus.oversampleRatio;

    // core clock halving as an enable phase
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            halvePhase_ff <= 1'b0;
        end else if (coreClockHalve) begin
            halvePhase_ff <= !halvePhase_ff;
        end else begin
            halvePhase_ff <= 1'b0;
        end
    end
    assign coreClkEnable = !coreClockHalve || halvePhase_ff;

    // Generator runs only when master, active and powered
    assign genEnable = clockMaster && interfaceActive && !powerOff;

    always_comb begin
        nxt_genState = genState_ff;
        case (genState_ff)
            GEN_IDLE: begin
                if (genEnable) begin
                    nxt_genState = GEN_RUN;
                end
            end
            GEN_RUN: begin
                if (!genEnable) begin
                    nxt_genState = GEN_IDLE;
                end
            end
            default: nxt_genState = GEN_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            genState_ff <= GEN_IDLE;
        end else begin
            genState_ff <= nxt_genState;
        end
    end

    assign halfDone = coreClkEnable && tickCnt_ff == 4'(codec_ctrl_pkg::BCLK_HALF_TICKS - 1);

    always_ff @(posedge core_clk) begin
        if (sys_rst || genState_ff != GEN_RUN) begin
            tickCnt_ff <= 4'h0;
        end else if (halfDone) begin
            tickCnt_ff <= 4'h0;
        end else if (coreClkEnable) begin
            tickCnt_ff <= tickCnt_ff + 4'h1;
        end
    end

    // Frame advances on the falling bit clock so data sees a full high half
    always_ff @(posedge core_clk) begin
        if (sys_rst || genState_ff != GEN_RUN) begin
            bclk_ff <= 1'b0;
            bitCnt_ff <= 6'h00;
        end else if (halfDone) begin
            bclk_ff <= !bclk_ff;
            if (bclk_ff) begin
                bitCnt_ff <= bitCnt_ff + 6'h01;
            end
        end
    end

    // DSP frame is a one-bit pulse, other formats a half-frame level
    always_comb begin
        if (formatSel == codec_ctrl_pkg::FMT_DSP) begin
            frameRaw = bitCnt_ff == 6'h00;
        end else begin
            frameRaw = bitCnt_ff[5];
        end
    end

    // bit clock inversion on the driven pin
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bitClkOut_ff <= 1'b0;
            dacFrameOut_ff <= 1'b0;
            adcFrameOut_ff <= 1'b0;
        end else begin
            bitClkOut_ff <= bclk_ff ^ bitClockInvert;
            dacFrameOut_ff <= frameRaw && genState_ff == GEN_RUN;
            adcFrameOut_ff <= frameRaw && genState_ff == GEN_RUN;
        end
    end

    assign bitClkOut = bitClkOut_ff;
    assign dacFrameOut = dacFrameOut_ff;
    assign adcFrameOut = adcFrameOut_ff;
    assign bitClkOe = clockMaster;
    assign dacFrameOe = clockMaster;
    assign adcFrameOe = clockMaster;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bclkSync_ff <= 2'h0;
            dacSync_ff <= 2'h0;
            adcSync_ff <= 2'h0;
        end else begin
            bclkSync_ff <= {bclkSync_ff[0], bitClkIn};
            dacSync_ff <= {dacSync_ff[0], dacFrameIn};
            adcSync_ff <= {adcSync_ff[0], adcFrameIn};
        end
    end

    assign frameLevel = clockMaster ? dacFrameOut_ff : dacSync_ff[1];

    // right channel phase, opposite in I2S
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rightNow_ff <= 1'b0;
        end else if (formatSel == codec_ctrl_pkg::FMT_DSP) begin
            rightNow_ff <= 1'b0;
        end else if (formatSel == codec_ctrl_pkg::FMT_I2S) begin
            rightNow_ff <= frameLevel != fbus.phaseSel;
        end else begin
            rightNow_ff <= frameLevel == fbus.phaseSel;
        end
    end
    assign rightChannelNow = rightNow_ff;

AST_PWR_WRITE:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        ctrlWrite && ctrlAddr == codec_ctrl_pkg::ADDR_POWER |=>
        lineInPowerDown == $past(ctrlWdata[0]) && dacPowerDown == $past(ctrlWdata[3]))
        else $error("power-down bits did not follow the write");

AST_RESET_DEFAULTS:
    assert property (@(posedge core_clk)
        sys_rst |=> powerOff && lineOutPowerDown && formatSel == 2'h2 && sampleRateCode == 4'h0
        && !interfaceActive && !clockMaster)
        else $error("fields not at defaults after reset");

AST_POWEROFF_VMID:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        powerOff |-> !standby && !vmidEnable)
        else $error("reference alive or standby during power-off");

AST_WORD_BITS:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        ctrlWrite && ctrlAddr == codec_ctrl_pkg::ADDR_FORMAT && ctrlWdata[3:2] == 2'h1 |=> wordBits == 6'h14)
        else $error("word length code 01 not 20 bits");

AST_DSP_MSB:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        formatSel == codec_ctrl_pkg::FMT_DSP |-> msbDelay == (formatReg_ff[codec_ctrl_pkg::FMT_PHASE] ? 2'h2 : 2'h1))
        else $error("DSP MSB edge wrong");

AST_SLAVE_NO_DRIVE:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        !clockMaster |-> !bitClkOe && !dacFrameOe && !adcFrameOe)
        else $error("slave drives audio clocks");

AST_RATIO:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        fixedClockMode |-> oversampleRatio == codec_ctrl_pkg::OSR_250 || oversampleRatio == codec_ctrl_pkg::OSR_272)
        else $error("fixed-clock mode ratio wrong");

AST_HALVE:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        coreClockHalve && coreClkEnable && !ctrlWrite |=> !coreClkEnable)
        else $error("halved core clock enabled twice in a row");

AST_PHASE_I2S:
    assert property (@(posedge core_clk) disable iff (sys_rst)
        formatSel == codec_ctrl_pkg::FMT_I2S && $stable(formatReg_ff) && !clockMaster
        |=> rightChannelNow == ($past(dacSync_ff[1]) != $past(formatReg_ff[codec_ctrl_pkg::FMT_PHASE])))
        else $error("I2S right-channel phase wrong");
endmodule : codec_ctrl_regs

/* File: bench/host_model.sv */
// Host model: issues control-port writes and moves the readback address.
// Assumes the bench calls its tasks from one thread; signals change at the falling edge.
`timescale 1ns/100ps
module host_model (
    input wire logic core_clk,
    output logic ctrlWrite,
    output logic [6:0] ctrlAddr,
    output logic [8:0] ctrlWdata
);
    initial begin
        ctrlWrite = 1'b0;
        ctrlAddr = 7'h00;
        ctrlWdata = 9'h000;
    end
    function automatic logic [8:0] legal(input logic [6:0] a, input logic [8:0] d);
        case (a)
            codec_ctrl_pkg::ADDR_POWER: legal = (d & 9'h09D) | 9'h062;
            codec_ctrl_pkg::ADDR_FORMAT: legal = d & 9'h0FF;
            codec_ctrl_pkg::ADDR_SAMPLING: legal = d & 9'h07F;
            codec_ctrl_pkg::ADDR_ACTIVATE: legal = d & 9'h001;
            default: legal = d;
        endcase
    endfunction : legal
    task automatic write_reg(input logic [6:0] a, input logic [8:0] d);
        @(negedge core_clk);
        ctrlWrite = 1'b1;
        ctrlAddr = a;
        ctrlWdata = legal(a, d);
        @(negedge core_clk);
        ctrlWrite = 1'b0;
        // Released data shows the inverse so a stale word is never mistaken for a live one
        ctrlWdata = ~ctrlWdata;
    endtask : write_reg
    task automatic set_addr(input logic [6:0] a);
        @(negedge core_clk);
        ctrlAddr = a;
    endtask : set_addr
    task automatic power_up(input logic [8:0] fmt, input logic [8:0] smp);
        write_reg(codec_ctrl_pkg::ADDR_POWER, 9'h010);
        write_reg(codec_ctrl_pkg::ADDR_FORMAT, fmt);
        write_reg(codec_ctrl_pkg::ADDR_SAMPLING, smp);
        write_reg(codec_ctrl_pkg::ADDR_ACTIVATE, 9'h001);
        write_reg(codec_ctrl_pkg::ADDR_POWER, 9'h000);
    endtask : power_up
endmodule : host_model

/* File: bench/codec_ctrl_regs_tb.sv */
// Testbench: register defaults, field decode, standby, unmapped access and audio clock pins.
// Assumes the host model drives the write port; pin inputs are driven here at the falling edge.
`timescale 1ns/100ps
module codec_ctrl_regs_tb;
    logic core_clk, sys_rst, ctrlWrite, bitClkIn, dacFrameIn, adcFrameIn;
    logic [6:0] ctrlAddr;
    logic [8:0] ctrlWdata, ctrlRdata, oversampleRatio;
    logic lineInPowerDown, adcPowerDown, dacPowerDown, lineOutPowerDown, powerOff, standby, vmidEnable;
    logic [1:0] formatSel, msbDelay;
    logic [5:0] wordBits;
    logic [3:0] sampleRateCode;
    logic dacChannelSwap, clockMaster, bitClockInvert, fixedClockMode, coreClockHalve, coreClkEnable;
    logic interfaceActive, rightChannelNow, bitClkOut, bitClkOe, dacFrameOut, dacFrameOe, adcFrameOut, adcFrameOe;
    int fail_count = 0;
    int check_count = 0;

    host_model host_model_inst (.core_clk(core_clk), .ctrlWrite(ctrlWrite), .ctrlAddr(ctrlAddr),
        .ctrlWdata(ctrlWdata));
    codec_ctrl_regs codec_ctrl_regs_inst (.core_clk(core_clk), .sys_rst(sys_rst), .ctrlWrite(ctrlWrite),
        .ctrlAddr(ctrlAddr), .ctrlWdata(ctrlWdata), .ctrlRdata(ctrlRdata), .lineInPowerDown(lineInPowerDown),
        .adcPowerDown(adcPowerDown), .dacPowerDown(dacPowerDown), .lineOutPowerDown(lineOutPowerDown),
        .powerOff(powerOff), .standby(standby), .vmidEnable(vmidEnable), .formatSel(formatSel),
        .wordBits(wordBits), .msbDelay(msbDelay), .dacChannelSwap(dacChannelSwap), .clockMaster(clockMaster),
        .bitClockInvert(bitClockInvert), .fixedClockMode(fixedClockMode), .oversampleRatio(oversampleRatio),
        .sampleRateCode(sampleRateCode), .coreClockHalve(coreClockHalve), .coreClkEnable(coreClkEnable),
        .interfaceActive(interfaceActive), .rightChannelNow(rightChannelNow), .bitClkIn(bitClkIn),
        .bitClkOut(bitClkOut), .bitClkOe(bitClkOe), .dacFrameIn(dacFrameIn), .dacFrameOut(dacFrameOut),
        .dacFrameOe(dacFrameOe), .adcFrameIn(adcFrameIn), .adcFrameOut(adcFrameOut), .adcFrameOe(adcFrameOe));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd(input logic [6:0] a, input logic [8:0] exp);
        host_model_inst.set_addr(a);
        @(negedge core_clk);
        check(ctrlRdata, exp);
    endtask : rd

    function automatic logic pick(input int sel);
        pick = (sel == 0) ? bitClkOut : dacFrameOut;
    endfunction : pick

    // Counts core cycles of one high phase; every wait is bounded
    task automatic measure_high(input int sel, output int n);
        int k;
        n = 0;
        k = 0;
        while (pick(sel) !== 1'b0 && k < 600) begin
            @(negedge core_clk);
            k++;
        end
        while (pick(sel) !== 1'b1 && k < 600) begin
            @(negedge core_clk);
            k++;
        end
        while (pick(sel) === 1'b1 && k < 600) begin
            @(negedge core_clk);
            n++;
            k++;
        end
        if (k >= 600) begin
            fail_count++;
            $display("[ERR] %0t pin never toggled", $time);
            wrap_up();
        end
    endtask : measure_high

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        $display("[ERR] %0t run hung", $time);
        wrap_up();
    end

    initial begin
        int f, p, s, n;
        logic [8:0] w;
        logic e0, e1;
        sys_rst = 1'b1;
        bitClkIn = 1'b0;
        dacFrameIn = 1'b0;
        adcFrameIn = 1'b0;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        rd(codec_ctrl_pkg::ADDR_POWER, 9'h09D);
        rd(codec_ctrl_pkg::ADDR_FORMAT, 9'h00A);
        rd(codec_ctrl_pkg::ADDR_SAMPLING, 9'h000);
        rd(codec_ctrl_pkg::ADDR_ACTIVATE, 9'h000);
        check({4'h0, powerOff, lineOutPowerDown, dacPowerDown, adcPowerDown, lineInPowerDown}, 9'h01F);
        check({7'h00, standby, vmidEnable}, 9'h000);
        check({5'h00, formatSel, wordBits == 6'h18, clockMaster}, 9'h00A);
        // Unmapped places hold nothing
        host_model_inst.write_reg(7'h0A, 9'h1FF);
        rd(7'h0A, 9'h000);
        rd(7'h05, 9'h000);
        host_model_inst.write_reg(codec_ctrl_pkg::ADDR_POWER, 9'h07F);
        check({4'h0, powerOff, lineOutPowerDown, dacPowerDown, adcPowerDown, lineInPowerDown}, 9'h00F);
        check({7'h00, standby, vmidEnable}, 9'h003);
        host_model_inst.write_reg(codec_ctrl_pkg::ADDR_POWER, 9'h062);
        check({4'h0, lineOutPowerDown, dacPowerDown, adcPowerDown, lineInPowerDown, standby}, 9'h000);
        rd(codec_ctrl_pkg::ADDR_POWER, 9'h062);
        for (f = 0; f < 4; f++) begin
            for (p = 0; p < 2; p++) begin
                w = {1'b0, p[0], p[0], p[0], p[0], 2'(f), 2'(f)};
                host_model_inst.write_reg(codec_ctrl_pkg::ADDR_FORMAT, w);
                check({7'h00, formatSel}, 9'(f));
                check({3'h0, wordBits}, (f == 3) ? 9'h020 : 9'(16 + 4 * f));
                check({7'h00, msbDelay}, (f == 3) ? 9'(1 + p) : ((f == 2) ? 9'h001 : 9'h000));
                check({6'h00, dacChannelSwap, clockMaster, bitClockInvert}, p[0] ? 9'h007 : 9'h000);
                rd(codec_ctrl_pkg::ADDR_FORMAT, w);
            end
        end
        for (s = 0; s < 4; s++) begin
            w = {2'b00, s[0], 4'(15 - s), s[1], s[0]};
            host_model_inst.write_reg(codec_ctrl_pkg::ADDR_SAMPLING, w);
            check({6'h00, fixedClockMode, coreClockHalve, 1'b0}, s[0] ? 9'h006 : 9'h000);
            check({5'h00, sampleRateCode}, 9'(15 - s));
            check(oversampleRatio, (s == 0) ? codec_ctrl_pkg::OSR_256 : (s == 1) ? codec_ctrl_pkg::OSR_250
                : (s == 2) ? codec_ctrl_pkg::OSR_384 : codec_ctrl_pkg::OSR_272);
            e0 = coreClkEnable;
            @(negedge core_clk);
            e1 = coreClkEnable;
            check({8'h00, s[0] ? (e0 ^ e1) : (e0 & e1)}, 9'h001);
            rd(codec_ctrl_pkg::ADDR_SAMPLING, w);
        end
        // Slave: external bit clock toggles, the device must not drive
        host_model_inst.power_up(9'h002, 9'h000);
        for (n = 0; n < 8; n++) begin
            @(negedge core_clk);
            bitClkIn = ~bitClkIn;
            dacFrameIn = n[2];
            adcFrameIn = n[2];
            @(negedge core_clk);
            check({5'h00, bitClkOe, dacFrameOe, adcFrameOe, bitClkOut | dacFrameOut | adcFrameOut}, 9'h000);
        end
        // Frame pin high: right channel in I2S with phase 0, left in left-justified
        check({8'h00, rightChannelNow}, 9'h001);
        host_model_inst.write_reg(codec_ctrl_pkg::ADDR_FORMAT, 9'h001);
        @(negedge core_clk);
        check({8'h00, rightChannelNow}, 9'h000);
        host_model_inst.write_reg(codec_ctrl_pkg::ADDR_FORMAT, 9'h042);
        check({6'h00, bitClkOe, dacFrameOe, adcFrameOe}, 9'h007);
        measure_high(0, n);
        check(9'(n), 9'(codec_ctrl_pkg::BCLK_HALF_TICKS));
        measure_high(1, n);
        check(9'(n), 9'(2 * codec_ctrl_pkg::BCLK_HALF_TICKS * codec_ctrl_pkg::SLOT_BITS));
        host_model_inst.write_reg(codec_ctrl_pkg::ADDR_SAMPLING, 9'h040);
        measure_high(0, n);
        check(9'(n), 9'(2 * codec_ctrl_pkg::BCLK_HALF_TICKS));
        rd(codec_ctrl_pkg::ADDR_ACTIVATE, 9'h001);
        rd(codec_ctrl_pkg::ADDR_POWER, 9'h062);
        // Reset in mid-run restores every default
        @(negedge core_clk);
        sys_rst = 1'b1;
        @(negedge core_clk);
        sys_rst = 1'b0;
        check({6'h00, bitClkOe, interfaceActive, coreClockHalve}, 9'h000);
        rd(codec_ctrl_pkg::ADDR_POWER, 9'h09D);
        rd(codec_ctrl_pkg::ADDR_FORMAT, 9'h00A);
        wrap_up();
    end
endmodule : codec_ctrl_regs_tb
